//--- verilog/vid_pkg.sv
// Function
// [R01] Glyph source holds 256-glyph fonts, up to four, font chosen by software.
// [R02] Control bits 7:6 form the upper glyph source address bits.
// [R03] Character cell is 9 pixels wide by 14 scan lines.
// [R04] Display RAM uses the character address; glyph address is code plus scan line.
// [R05] Character address steps once per fetch; row end resets column, advances line.
// [R06] Display fetch beats host; host gets at most one access per character period.
// [R07] Host window is 245 ns per 512 ns period, one byte per window; code uses 9 clocks (225 ns) of a 21-clock (525 ns) period.
// [R08] Glyph byte and attribute load together; shift one pixel per dot.
// [R09] Ninth pixel column comes from separate logic, not the glyph byte.
// [R10] Five-bit index selects one of 18 registers; 18 to 31 select none.
// [R11] Horizontal total holds row period minus one, usually 61h.
// [R12] Horizontal displayed holds characters shown per row, usually 50h.
// [R13] Horizontal sync position sets sync start in characters, usually 52h.
// [R14] Sync widths: low nibble horizontal, high nibble vertical, usually 0fh.
// [R15] Vertical total counts rows minus one; adjust adds extra scan lines, 06h.
// [R16] Vertical displayed rows and vertical sync row, both usually 19h.
// [R17] Low two mode bits pick non-interlace, interlace sync, or sync and video.
// [R18] Skew fields delay display enable and cursor by 0, 1 or 2 characters.
// [R19] Maximum scan line holds lines per row minus one, normally 0dh.
// [R20] Cursor start line in low bits; bits 6:5 steady, off, fast or slow blink.
// [R21] Cursor end line; equal start and end gives a one-line cursor.
// [R22] Start address and cursor address are read/write 6-bit high, 8-bit low pairs.
// [R23] Host address bit 0 picks character or attribute RAM; scan reads both.
// [R24] Control port 3b8h: bit 0 gates host RAM access, bit 3 enables video.
// [R25] Host writes index to 3b4h before data access at 3b5h.
// [R26] Pixels are blank outside the programmed displayed region.
package vid_pkg;
  localparam int          NUM_REGS  = 18;
  localparam logic [4:0]  IDX_HTOT  = 5'h00;
  localparam logic [4:0]  IDX_HDISP = 5'h01;
  localparam logic [4:0]  IDX_HSPOS = 5'h02;
  localparam logic [4:0]  IDX_SWID  = 5'h03;
  localparam logic [4:0]  IDX_VTOT  = 5'h04;
  localparam logic [4:0]  IDX_VADJ  = 5'h05;
  localparam logic [4:0]  IDX_VDISP = 5'h06;
  localparam logic [4:0]  IDX_VSPOS = 5'h07;
  localparam logic [4:0]  IDX_ILACE = 5'h08;
  localparam logic [4:0]  IDX_MAXSL = 5'h09;
  localparam logic [4:0]  IDX_CSTRT = 5'h0a;
  localparam logic [4:0]  IDX_CEND  = 5'h0b;
  localparam logic [4:0]  IDX_SAHI  = 5'h0c;
  localparam logic [4:0]  IDX_SALO  = 5'h0d;
  localparam logic [4:0]  IDX_CAHI  = 5'h0e;
  localparam logic [4:0]  IDX_CALO  = 5'h0f;
  localparam logic [4:0]  IDX_PENHI = 5'h10;
  localparam logic [4:0]  IDX_PENLO = 5'h11;
  // Index 17 first; usual programmed values
  localparam logic [NUM_REGS*8-1:0] REG_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0b, 8'h0d,
    8'h02, 8'h19, 8'h19, 8'h06, 8'h19, 8'h0f, 8'h52, 8'h50, 8'h61};
  localparam logic [NUM_REGS*8-1:0] REG_MASK = {
    8'h00, 8'h00, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'h1f, 8'h7f, 8'h1f,
    8'hff, 8'h7f, 8'h7f, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [9:0]  PORT_INDEX   = 10'h3b4;
  localparam logic [9:0]  PORT_DATA    = 10'h3b5;
  localparam logic [9:0]  PORT_CTRL    = 10'h3b8;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam int          CTRL_RAM_BIT = 0;
  localparam int          CTRL_VID_BIT = 3;
  localparam int          CTRL_FONT_LO = 6;
  localparam int          ATTR_INT_BIT = 3;
  localparam int          BLINK_FAST   = 3;
  localparam int          BLINK_SLOW   = 4;
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          CHAR_PERIOD_NS = 512;
  localparam int          HOST_WIN_NS    = 245;
  localparam int          CHAR_CYC  = (CHAR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HOST_WIN_CYC = HOST_WIN_NS / CLK_PERIOD_NS;
  localparam int          DOT_CYC   = 2;
  localparam int          GLYPH_W   = 8;
  localparam int          CELL_W    = 9;
  localparam int          CELL_H    = 14;
  localparam logic [4:0]  CHAR_LAST = 5'(CHAR_CYC - 1);
  localparam logic [4:0]  ROM_PHASE = 5'h01;
  localparam logic [4:0]  WIN_FIRST = 5'h0a;
  localparam logic [4:0]  WIN_LAST  = 5'(10 + HOST_WIN_CYC - 1);
  localparam logic [4:0]  SHIFT_END = 5'(DOT_CYC * (GLYPH_W - 1));
  localparam logic [4:0]  COL9_PH   = 5'(DOT_CYC * GLYPH_W);
  localparam logic [2:0]  COL9_CODE = 3'h6;
endpackage : vid_pkg

//--- verilog/display_ram.sv
`timescale 1ns/1ps
module display_ram (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [10:0] addr_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:2047];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule : display_ram

//--- verilog/pixel_serializer.sv
`timescale 1ns/1ps
module pixel_serializer (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       load_in,
  input  wire logic       shift_in,
  input  wire logic       col9_in,
  input  wire logic [7:0] glyph_in,
  input  wire logic [7:0] attr_in,
  input  wire logic [7:0] code_in,
  output logic            pixel_out,
  output logic      [7:0] attr_out
);
  logic [7:0] sh_r;
  logic       ext_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_r     <= 8'h00;
      attr_out <= 8'h00;
      ext_r    <= 1'b0;
    end else if (load_in) begin
      sh_r     <= glyph_in; // R08
      attr_out <= attr_in; // R08
      ext_r    <= (code_in[7:5] == vid_pkg::COL9_CODE) && glyph_in[0]; // R09
    end else if (shift_in) begin
      sh_r     <= {sh_r[6:0], 1'b0}; // R08
    end
  end

  // Ninth column repeats the last glyph pixel only for line-drawing codes
  assign pixel_out = col9_in ? ext_r : sh_r[7]; // R09

  property p_load;
    @(posedge clk_in) disable iff (!rst_n_in) load_in |=> attr_out == $past(attr_in);
  endproperty
  a_load: assert property (p_load) // R08
    else $error("attribute not latched with glyph");
endmodule : pixel_serializer

//--- verilog/text_display_top.sv
`timescale 1ns/1ps
module text_display_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [9:0]  HOST_IO_ADDR_IN,
  input  wire logic        HOST_IO_WR_IN,
  input  wire logic        HOST_IO_RD_IN,
  input  wire logic [7:0]  HOST_IO_WDATA_IN,
  output logic      [7:0]  HOST_IO_RDATA_OUT,
  input  wire logic        HOST_MEM_REQ_IN,
  input  wire logic        HOST_MEM_WE_IN,
  input  wire logic [11:0] HOST_MEM_ADDR_IN,
  input  wire logic [7:0]  HOST_MEM_WDATA_IN,
  output logic      [7:0]  HOST_MEM_RDATA_OUT,
  output logic             HOST_MEM_ACK_OUT,
  output logic      [13:0] ROM_ADDR_OUT,
  input  wire logic [7:0]  ROM_DATA_IN,
  output logic             VIDEO_OUT,
  output logic             INTENSITY_OUT,
  output logic             HSYNC_OUT,
  output logic             VSYNC_OUT
);
  logic [4:0]                           index_r;
  logic [7:0]                           ctrl_r;
  logic [vid_pkg::NUM_REGS-1:0][7:0]    regs_r;

  wire idx_wr  = HOST_IO_WR_IN && (HOST_IO_ADDR_IN == vid_pkg::PORT_INDEX);
  wire ctrl_wr = HOST_IO_WR_IN && (HOST_IO_ADDR_IN == vid_pkg::PORT_CTRL);
  wire dat_rd  = HOST_IO_RD_IN && (HOST_IO_ADDR_IN == vid_pkg::PORT_DATA);
  wire idx_ok  = index_r < 5'(vid_pkg::NUM_REGS); // R10
  wire reg_wr  = HOST_IO_WR_IN && (HOST_IO_ADDR_IN == vid_pkg::PORT_DATA)
                 && idx_ok; // R10 R25
  wire rd_ok   = idx_ok && (index_r >= vid_pkg::IDX_SAHI); // R22
  wire [7:0] rd_val = rd_ok ? regs_r[index_r] : 8'h00;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      index_r <= 5'h00;
      ctrl_r  <= vid_pkg::CTRL_RST;
    end else begin
      if (idx_wr) begin
        index_r <= HOST_IO_WDATA_IN[4:0]; // R10
      end
      if (ctrl_wr) begin
        ctrl_r <= HOST_IO_WDATA_IN; // R24
      end
    end
  end

  // One write port per register; masks give each its documented width
  for (genvar i = 0; i < vid_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
        regs_r[i] <= vid_pkg::REG_RST[i*8 +: 8];
      end else if (reg_wr && (index_r == 5'(i))) begin
        regs_r[i] <= HOST_IO_WDATA_IN & vid_pkg::REG_MASK[i*8 +: 8]; // R11 R12
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HOST_IO_RDATA_OUT <= 8'h00;
    end else begin
      HOST_IO_RDATA_OUT <= dat_rd ? rd_val : 8'h00; // R22
    end
  end

  wire [7:0]  htot   = regs_r[vid_pkg::IDX_HTOT]; // R11
  wire [7:0]  hdisp  = regs_r[vid_pkg::IDX_HDISP]; // R12
  wire [7:0]  hspos  = regs_r[vid_pkg::IDX_HSPOS]; // R13
  wire [7:0]  swid   = regs_r[vid_pkg::IDX_SWID];
  wire [6:0]  vtot   = regs_r[vid_pkg::IDX_VTOT][6:0];
  wire [4:0]  vadj   = regs_r[vid_pkg::IDX_VADJ][4:0];
  wire [6:0]  vdisp  = regs_r[vid_pkg::IDX_VDISP][6:0];
  wire [6:0]  vspos  = regs_r[vid_pkg::IDX_VSPOS][6:0];
  wire [7:0]  ilace  = regs_r[vid_pkg::IDX_ILACE];
  wire [4:0]  maxsl  = regs_r[vid_pkg::IDX_MAXSL][4:0];
  wire [6:0]  cstrt  = regs_r[vid_pkg::IDX_CSTRT][6:0];
  wire [4:0]  cend   = regs_r[vid_pkg::IDX_CEND][4:0];
  wire [13:0] saddr  = {regs_r[vid_pkg::IDX_SAHI][5:0],
                        regs_r[vid_pkg::IDX_SALO]}; // R22
  wire [13:0] caddr  = {regs_r[vid_pkg::IDX_CAHI][5:0],
                        regs_r[vid_pkg::IDX_CALO]}; // R22
  wire        ram_en = ctrl_r[vid_pkg::CTRL_RAM_BIT]; // R24
  wire        vid_en = ctrl_r[vid_pkg::CTRL_VID_BIT]; // R24
  wire [1:0]  font   = ctrl_r[vid_pkg::CTRL_FONT_LO +: 2]; // R02

  logic [4:0] phase_r;
  wire        char_end = (phase_r == vid_pkg::CHAR_LAST);
  wire        fetch    = (phase_r == 5'h00);

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      phase_r <= 5'h00;
    end else begin
      phase_r <= char_end ? 5'h00 : phase_r + 5'h01;
    end
  end

  logic [7:0]  hcount_r;
  logic [4:0]  scan_r;
  logic [6:0]  row_r;
  logic [4:0]  adj_r;
  logic        in_adj_r;
  logic [13:0] row_base_r;
  logic [4:0]  frame_r;
  logic        field_r;

  wire        il_on    = ilace[0]; // R17
  wire        il_video = (ilace[1:0] == 2'b11); // R17
  wire [5:0]  step     = il_video ? 6'h02 : 6'h01;
  wire        line_end = char_end && (hcount_r == htot); // R11
  wire        row_done = ({1'b0, scan_r} + step) > {1'b0, maxsl}; // R19
  wire        last_row = (row_r == vtot); // R15
  wire        frame_done = line_end && (in_adj_r ? (adj_r == vadj - 5'h01)
                           : (row_done && last_row && (vadj == 5'h00))); // R15
  wire        enter_adj = line_end && !in_adj_r && row_done && last_row
                          && (vadj != 5'h00); // R15
  wire        field_nxt = il_on && !field_r; // R17
  wire [4:0]  scan_top  = il_video ? {4'h0, field_nxt} : 5'h00;
  wire [13:0] char_addr = row_base_r + {6'h00, hcount_r}; // R04 R05

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hcount_r <= 8'h00;
    end else if (line_end) begin
      hcount_r <= 8'h00; // R05
    end else if (char_end) begin
      hcount_r <= hcount_r + 8'h01; // R05
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      scan_r     <= 5'h00;
      row_r      <= 7'h00;
      adj_r      <= 5'h00;
      in_adj_r   <= 1'b0;
      row_base_r <= 14'h0000;
      frame_r    <= 5'h00;
      field_r    <= 1'b0;
    end else if (frame_done) begin
      scan_r     <= scan_top;
      row_r      <= 7'h00;
      adj_r      <= 5'h00;
      in_adj_r   <= 1'b0;
      row_base_r <= saddr; // R22
      frame_r    <= frame_r + 5'h01;
      field_r    <= field_nxt; // R17
    end else if (enter_adj) begin
      in_adj_r   <= 1'b1; // R15
      adj_r      <= 5'h00;
    end else if (line_end && in_adj_r) begin
      adj_r      <= adj_r + 5'h01; // R15
    end else if (line_end && row_done) begin
      row_r      <= row_r + 7'h01; // R05
      scan_r     <= il_video ? {4'h0, field_r} : 5'h00; // R19
      row_base_r <= row_base_r + {6'h00, hdisp}; // R05 R12
    end else if (line_end) begin
      scan_r     <= scan_r + step[4:0]; // R05
    end
  end

  // Display enable and cursor, before skew
  wire [1:0] cmode   = cstrt[6:5]; // R20
  wire       blink   = (cmode == 2'b00)
                       || ((cmode == 2'b10) && frame_r[vid_pkg::BLINK_FAST])
                       || ((cmode == 2'b11) && frame_r[vid_pkg::BLINK_SLOW]); // R20
  wire       de_raw  = (hcount_r < hdisp) && (row_r < vdisp) && !in_adj_r; // R12 R16
  wire       cur_raw = (char_addr == caddr) && !in_adj_r
                       && (scan_r >= cstrt[4:0]) && (scan_r <= cend)
                       && blink; // R20 R21

  // Skew pipes; code 11 is not allowed and is held at two characters
  logic [2:0] de_pipe_r;
  logic [2:0] cur_pipe_r;
  wire  [1:0] de_sk  = (ilace[5:4] == 2'b11) ? 2'b10 : ilace[5:4]; // R18
  wire  [1:0] cur_sk = (ilace[7:6] == 2'b11) ? 2'b10 : ilace[7:6]; // R18
  wire        de_now  = de_pipe_r[de_sk]; // R18
  wire        cur_now = cur_pipe_r[cur_sk]; // R18

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      de_pipe_r  <= 3'h0;
      cur_pipe_r <= 3'h0;
    end else if (char_end) begin
      de_pipe_r  <= {de_pipe_r[1:0], de_raw};
      cur_pipe_r <= {cur_pipe_r[1:0], cur_raw};
    end
  end

  wire [4:0] hs_w  = (swid[3:0] == 4'h0) ? 5'h10 : {1'b0, swid[3:0]}; // R14
  wire [4:0] vs_w  = (swid[7:4] == 4'h0) ? 5'h10 : {1'b0, swid[7:4]}; // R14
  wire [8:0] hs_hi = {1'b0, hspos} + {4'h0, hs_w};
  wire       hs_on = (hcount_r >= hspos) && ({1'b0, hcount_r} < hs_hi); // R13
  wire       vs_go = line_end && (frame_done ? (vspos == 7'h00)
                     : (!in_adj_r && !enter_adj && row_done
                        && (row_r + 7'h01 == vspos))); // R16
  logic [4:0] vs_cnt_r;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      vs_cnt_r <= 5'h00;
    end else if (vs_go) begin
      vs_cnt_r <= vs_w; // R14
    end else if (line_end && (vs_cnt_r != 5'h00)) begin
      vs_cnt_r <= vs_cnt_r - 5'h01;
    end
  end

  // Host access slot: one grant per period, never in the fetch cycle
  logic       served_r;
  logic       grant_d1_r;
  logic       hsel_r;
  wire        in_win = (phase_r >= vid_pkg::WIN_FIRST)
                       && (phase_r <= vid_pkg::WIN_LAST); // R07
  wire        grant  = in_win && HOST_MEM_REQ_IN && !served_r; // R06 R07
  wire        h_we   = grant && HOST_MEM_WE_IN && ram_en; // R24
  wire        hsel   = HOST_MEM_ADDR_IN[0]; // R23
  wire [10:0] ram_a  = fetch ? char_addr[10:0]
                       : HOST_MEM_ADDR_IN[11:1]; // R04 R06 R23
  wire        chr_we = h_we && !hsel; // R23
  wire        atr_we = h_we && hsel; // R23
  wire [7:0]  chr_q;
  wire [7:0]  atr_q;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      served_r   <= 1'b0;
      grant_d1_r <= 1'b0;
      hsel_r     <= 1'b0;
      HOST_MEM_ACK_OUT   <= 1'b0;
      HOST_MEM_RDATA_OUT <= 8'h00;
    end else begin
      served_r   <= char_end ? 1'b0 : (served_r || grant); // R06
      grant_d1_r <= grant;
      hsel_r     <= grant ? hsel : hsel_r;
      HOST_MEM_ACK_OUT <= grant_d1_r; // R07
      if (grant_d1_r) begin
        HOST_MEM_RDATA_OUT <= !ram_en ? 8'h00 : (hsel_r ? atr_q : chr_q); // R23 R24
      end
    end
  end

  display_ram u_chr_ram (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .addr_in   (ram_a),
    .we_in     (chr_we),
    .wdata_in  (HOST_MEM_WDATA_IN),
    .rdata_out (chr_q)
  );

  display_ram u_atr_ram (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .addr_in   (ram_a),
    .we_in     (atr_we),
    .wdata_in  (HOST_MEM_WDATA_IN),
    .rdata_out (atr_q)
  );

  // Capture fetched bytes before a host read reuses the RAM outputs
  logic [7:0] fch_code_r;
  logic [7:0] fch_attr_r;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      fch_code_r   <= 8'h00;
      fch_attr_r   <= 8'h00;
      ROM_ADDR_OUT <= 14'h0000;
    end else if (phase_r == vid_pkg::ROM_PHASE) begin
      fch_code_r   <= chr_q;
      fch_attr_r   <= atr_q;
      ROM_ADDR_OUT <= {font, chr_q, scan_r[3:0]}; // R01 R02 R04
    end
  end

  // Pixel shifting: one dot per two clocks, ninth column at the end
  wire       shift = phase_r[0] && (phase_r <= vid_pkg::SHIFT_END); // R08
  wire       col9  = (phase_r >= vid_pkg::COL9_PH); // R03 R09
  wire       pix;
  wire [7:0] attr_q;

  pixel_serializer u_ser (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .load_in   (char_end),
    .shift_in  (shift),
    .col9_in   (col9),
    .glyph_in  (ROM_DATA_IN),
    .attr_in   (fch_attr_r),
    .code_in   (fch_code_r),
    .pixel_out (pix),
    .attr_out  (attr_q)
  );

  wire show = vid_en && de_now; // R24 R26

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      VIDEO_OUT     <= 1'b0;
      INTENSITY_OUT <= 1'b0;
      HSYNC_OUT     <= 1'b0;
      VSYNC_OUT     <= 1'b0;
    end else begin
      VIDEO_OUT     <= show && (pix || cur_now); // R26
      INTENSITY_OUT <= show && attr_q[vid_pkg::ATTR_INT_BIT]; // R26
      HSYNC_OUT     <= hs_on; // R13
      VSYNC_OUT     <= (vs_cnt_r != 5'h00); // R16
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_ack2;
    ##2 HOST_MEM_ACK_OUT;
  endsequence
  sequence s_no_ack;
    !HOST_MEM_ACK_OUT [*2];
  endsequence
  property p_idx_none;
    (HOST_IO_WR_IN && HOST_IO_ADDR_IN == vid_pkg::PORT_DATA && index_r >= 5'h12)
      |=> $stable(regs_r);
  endproperty
  a_idx_none: assert property (p_idx_none) // R10
    else $error("out of range index changed a register");
  property p_fetch_first;
    (chr_we || atr_we) |-> !fetch && in_win;
  endproperty
  a_fetch_first: assert property (p_fetch_first) // R06
    else $error("host write outside its window");
  property p_one_grant;
    grant |=> !grant until_with char_end;
  endproperty
  a_one_grant: assert property (p_one_grant) // R07
    else $error("second host grant in one period");
  property p_ack;
    grant |-> s_ack2;
  endproperty
  a_ack: assert property (p_ack) // R07
    else $error("host access not acknowledged two cycles after grant");
  // No grant now or just before: no acknowledge on either of the next two edges
  property p_idle_no_ack;
    (!grant && !grant_d1_r) |=> s_no_ack;
  endproperty
  a_idle_no_ack: assert property (p_idle_no_ack) // R07
    else $error("acknowledge without grant");
  property p_addr_step;
    (char_end && !line_end) |=> hcount_r == $past(hcount_r) + 8'h01;
  endproperty
  a_addr_step: assert property (p_addr_step) // R05
    else $error("character address did not step by one");
  property p_wrap;
    line_end |=> hcount_r == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) // R05
    else $error("column did not return to zero at row end");
  property p_blank;
    !show |=> !VIDEO_OUT && !INTENSITY_OUT;
  endproperty
  a_blank: assert property (p_blank) // R26
    else $error("pixel lit outside displayed region");
  property p_font;
    (phase_r == 5'h02) |-> ROM_ADDR_OUT[13:12] == $past(font);
  endproperty
  a_font: assert property (p_font) // R02
    else $error("glyph address lacks font bits");
endmodule : text_display_top

//--- verification/glyph_rom_model.sv
`timescale 1ns/1ps
module glyph_rom_model (
  input  wire logic [13:0] addr_in,
  output logic      [7:0]  data_out
);
  // Pattern depends on font, code and scan line so address slips show
  assign data_out = addr_in[11:4] ^ {addr_in[13:12], 2'h0, addr_in[3:0]};
endmodule : glyph_rom_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, io_wstb, io_rd, req, we;
  logic [9:0]  io_addr;
  logic [7:0]  io_wd, io_rdata, wd, rdata, rom_d;
  logic [11:0] addr;
  logic [13:0] rom_a;
  logic        ack, vid, inten, hs, vs;
  int n_mismatch, compares, cyc, t_ack;
  text_display_top i_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .HOST_IO_ADDR_IN(io_addr),
    .HOST_IO_WR_IN(io_wstb), .HOST_IO_RD_IN(io_rd), .HOST_IO_WDATA_IN(io_wd),
    .HOST_IO_RDATA_OUT(io_rdata), .HOST_MEM_REQ_IN(req), .HOST_MEM_WE_IN(we),
    .HOST_MEM_ADDR_IN(addr), .HOST_MEM_WDATA_IN(wd), .HOST_MEM_RDATA_OUT(rdata),
    .HOST_MEM_ACK_OUT(ack), .ROM_ADDR_OUT(rom_a), .ROM_DATA_IN(rom_d), .VIDEO_OUT(vid),
    .INTENSITY_OUT(inten), .HSYNC_OUT(hs), .VSYNC_OUT(vs));
  glyph_rom_model i_rom (.addr_in(rom_a), .data_out(rom_d));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic io_wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk) begin io_addr <= a; io_wd <= d; io_wstb <= 1'b1; end
    @(posedge clk) io_wstb <= 1'b0;
  endtask : io_wr
  task automatic reg_rd(logic [4:0] idx, output logic [7:0] d);
    io_wr(vid_pkg::PORT_INDEX, {3'h0, idx});
    @(posedge clk) begin io_addr <= vid_pkg::PORT_DATA; io_rd <= 1'b1; end
    @(posedge clk) io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask : reg_rd
  task automatic mem(logic w, logic [11:0] a, logic [7:0] d, output logic [7:0] q);
    int i;
    @(posedge clk) begin req <= 1'b1; we <= w; addr <= a; wd <= d; end
    for (i = 0; i < 40 && ack !== 1'b1; i++) @(negedge clk);
    if (ack !== 1'b1) begin n_mismatch++; wrap_up(); end
    q = rdata;
    t_ack = cyc;
    @(posedge clk) req <= 1'b0;
  endtask : mem
  task automatic wait_lvl(ref logic s, input logic lv, input int lim, output int n);
    for (n = 0; n < lim && s !== lv; n++) @(negedge clk);
    if (n == lim) begin n_mismatch++; wrap_up(); end
  endtask : wait_lvl
  task automatic sc_regs;
    logic [7:0] d;
    io_wr(vid_pkg::PORT_INDEX, 8'h0e);
    io_wr(vid_pkg::PORT_DATA, 8'hff);
    reg_rd(5'h0e, d); chk("cursor_address_high", 16'h003f, {8'h0, d});
    io_wr(vid_pkg::PORT_DATA, 8'ha5);
    reg_rd(5'h0d, d); chk("start_address_low", 16'h0000, {8'h0, d});
    io_wr(vid_pkg::PORT_INDEX, 8'h0d);
    io_wr(vid_pkg::PORT_DATA, 8'ha5);
    reg_rd(5'h0d, d); chk("start_address_low", 16'h00a5, {8'h0, d});
    io_wr(vid_pkg::PORT_INDEX, 8'h12);
    io_wr(vid_pkg::PORT_DATA, 8'h77);
    reg_rd(5'h0d, d); chk("start_address_low", 16'h00a5, {8'h0, d});
    reg_rd(5'h00, d); chk("horizontal_total", 16'h0000, {8'h0, d});
    reg_rd(5'h10, d); chk("pen_strike_high", 16'h0000, {8'h0, d});
    io_wr(vid_pkg::PORT_INDEX, 8'h0d);
    io_wr(vid_pkg::PORT_DATA, 8'h00);
  endtask : sc_regs
  task automatic sc_mem;
    logic [7:0] q;
    int t0, gap;
    mem(1'b1, 12'h000, 8'h41, q);
    mem(1'b0, 12'h000, 8'h00, q); chk("blocked read", 16'h0000, {8'h0, q});
    io_wr(vid_pkg::PORT_CTRL, 8'h01);
    mem(1'b1, 12'h000, 8'h41, q);
    t0 = t_ack;
    mem(1'b1, 12'h001, 8'h08, q);
    // Grants fall in phases 10..18 of distinct periods, so 13 to 21 cycles apart
    gap = t_ack - t0;
    chk("ack spacing ok", 16'h1, {15'h0, gap >= vid_pkg::CHAR_CYC - 8 && gap <= vid_pkg::CHAR_CYC});
    mem(1'b0, 12'h000, 8'h00, q); chk("char byte", 16'h0041, {8'h0, q});
    mem(1'b0, 12'h001, 8'h00, q); chk("attr byte", 16'h0008, {8'h0, q});
  endtask : sc_mem
  task automatic sc_video;
    int n, lit, hi;
    lit = 0;
    hi = 0;
    for (n = 0; n < 2200; n++) begin
      @(negedge clk);
      if (vid === 1'b1) lit = 1;
      if (inten === 1'b1) hi = 1;
    end
    chk("video while disabled", 16'h0, lit[15:0]);
    chk("intensity while disabled", 16'h0, hi[15:0]);
    io_wr(vid_pkg::PORT_CTRL, 8'hc9);
    for (n = 0; n < 50000 && !(lit && hi); n++) begin
      @(negedge clk);
      if (vid === 1'b1) lit = 1;
      if (inten === 1'b1) hi = 1;
    end
    chk("video lit", 16'h1, lit[15:0]);
    chk("intensity lit", 16'h1, hi[15:0]);
    chk("font bits", 16'h3, {14'h0, rom_a[13:12]});
  endtask : sc_video
  task automatic sc_hsync;
    int n;
    wait_lvl(hs, 1'b0, 3000, n);
    wait_lvl(hs, 1'b1, 3000, n);
    wait_lvl(hs, 1'b0, 3000, n);
    chk("hsync width", 16'(15 * vid_pkg::CHAR_CYC), 16'(n));
    chk("vsync idle", 16'h0, {15'h0, vs});
    wait_lvl(hs, 1'b1, 3000, n);
    chk("row period", 16'(98 * vid_pkg::CHAR_CYC), 16'(n + 15 * vid_pkg::CHAR_CYC));
  endtask : sc_hsync
  initial begin
    rst_n = 1'b0; io_wstb = 1'b0; io_rd = 1'b0; io_addr = '0; io_wd = '0;
    req = 1'b0; we = 1'b0; addr = '0; wd = '0;
    n_mismatch = 0; compares = 0; cyc = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_mem();
    sc_hsync();
    sc_video();
    wrap_up();
  end
endmodule : tb
